// ===== rtl/bpc_params.svh
// constants for the boot packet command interpreter
`ifndef BPC_PARAMS_SVH
`define BPC_PARAMS_SVH

`define BPC_CLK_HZ        200_000_000
`define BPC_LINE_RATE     57600
`define BPC_FRAME_LIMIT   19
`define BPC_PAYLOAD_BUF   19
`define BPC_START_BYTE    8'h80
`define BPC_ERASED_BYTE   8'hFF
`define BPC_SEG_BITS      9
`define BPC_SPI_HALF      4
`define BPC_RADIO_RD_CMD  8'hFF

`define BPC_CMD_PROGRAM   8'h10
`define BPC_CMD_ERASE_SEG 8'h12
`define BPC_CMD_ERASE_ALL 8'h15
`define BPC_CMD_VERSION   8'h19
`define BPC_CMD_LAUNCH    8'h1C

`define BPC_RSP_OK        8'h00
`define BPC_RSP_HEADER    8'h51
`define BPC_RSP_CHECKSUM  8'h52
`define BPC_RSP_EMPTY     8'h53
`define BPC_RSP_OVERSIZE  8'h54
`define BPC_RSP_FAULT     8'h55
`define BPC_RSP_BAD_CMD   8'h56
`define BPC_RSP_BAD_ARG   8'hC5

`define BPC_CRC_POLY      16'h1021
`define BPC_CRC_INIT      16'hFFFF
`define BPC_APP_LO        24'h00_4400
`define BPC_APP_HI        24'h00_FBFF
`define BPC_VERSION       8'h3C

`endif

// ===== rtl/bpc_pkg.sv
// types for the boot packet command interpreter
package bpc_pkg;

  typedef enum logic [8:0] {
    ST_HEAD  = 9'h001,
    ST_LEN   = 9'h002,
    ST_PAY   = 9'h004,
    ST_CRCL  = 9'h008,
    ST_CRCH  = 9'h010,
    ST_EXEC  = 9'h020,
    ST_ERASE = 9'h040,
    ST_PROG  = 9'h080,
    ST_REPLY = 9'h100
  } bpc_state_e;

  typedef struct packed {
    logic        wr;
    logic [23:0] addr;
    logic [7:0]  data;
  } bpc_mem_s;

  typedef struct packed {
    logic       busy;
    logic       miso_s1;
    logic       miso_s2;
    logic       sclk;
    logic       mosi;
    logic       cs_n;
    logic       done;
    logic [3:0] bits;
    logic [7:0] cnt;
    logic [7:0] sh;
  } bpc_spi_s;

endpackage : bpc_pkg

// ===== rtl/bpc_spi_master.sv
// byte engine for the radio serial bus
`timescale 1ns/1ps
`include "bpc_params.svh"
module bpc_spi_master import bpc_pkg::*; #(
  parameter int HALF = `BPC_SPI_HALF
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       go,
  input  wire logic [7:0] tx_byte,
  input  wire logic       miso,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rx_byte,
  output logic            sclk,
  output logic            mosi,
  output logic            chip_select_line_n
);

  bpc_spi_s s;
  bpc_spi_s next_s;

  always_comb begin
    next_s         = s;
    next_s.miso_s1 = miso;
    next_s.miso_s2 = s.miso_s1;
    next_s.done    = 1'b0;
    if (!s.busy) begin
      if (go) begin
        next_s.busy = 1'b1;
        next_s.cs_n = 1'b0;
        next_s.sh   = tx_byte;
        next_s.mosi = tx_byte[7];
        next_s.bits = 4'h0;
        next_s.cnt  = 8'(HALF - 1);
      end
    end else if (s.cnt != 8'h00) begin
      next_s.cnt = s.cnt - 8'h01;
    end else begin
      next_s.cnt = 8'(HALF - 1);
      if (!s.sclk) begin
        if (s.bits == 4'h8) begin
          next_s.busy = 1'b0;
          next_s.cs_n = 1'b1;
          next_s.done = 1'b1;
        end else begin
          next_s.sclk = 1'b1;
        end
      end else begin
        next_s.sclk = 1'b0;
        next_s.sh   = {s.sh[6:0], s.miso_s2};
        next_s.mosi = s.sh[6];
        next_s.bits = s.bits + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s      <= '0;
      s.cs_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign busy               = s.busy;
  assign done               = s.done;
  assign rx_byte            = s.sh;
  assign sclk               = s.sclk;
  assign mosi               = s.mosi;
  assign chip_select_line_n = s.cs_n;

endmodule : bpc_spi_master

// ===== rtl/bpc_interpreter.sv
// boot packet command interpreter: serial and radio links, parser, executor
// Function
// - serial bytes are 8 data, no parity, 1 stop
// - serial line runs at configurable 57600 baud
// - radio bus words are 8 bits, msb first
// - radio clock idles low, capture first edge
// - packet starts with 0x80, else rejected
// - length byte valid from one to limit
// - payload: command, address low-mid-high, data
// - low-first checksum is crc over payload
// - length one carries the command only
// - 0x12 erases 512-byte segment holding address
// - 0x15 erases the whole application region
// - 0x10 programs data bytes from address onward
// - 0x19 replies with the loader version
// - 0x1C validates image then launches it
// - every reply is exactly one byte
// - successful command other than 0x19 replies 0x00
// - bad start 0x51, bad checksum 0x52
// - zero length replies 0x53
// - length above limit replies 0x54
// - bad parameters reply 0xC5
// - unknown command 0x56, other faults 0x55
// - radio packet at most 23 bytes
// - reply sent unprompted once processing ends
// - erased bytes are written with 0xFF
`timescale 1ns/1ps
`include "bpc_params.svh"
module bpc_interpreter import bpc_pkg::*; #(
  parameter int          line_rate_setting = `BPC_LINE_RATE,
  parameter int          frame_len_limit   = `BPC_FRAME_LIMIT,
  parameter logic [23:0] app_lo            = `BPC_APP_LO,
  parameter logic [23:0] app_hi            = `BPC_APP_HI,
  parameter logic [7:0]  loader_version    = `BPC_VERSION, // arbitrary value
  parameter int          spi_half          = `BPC_SPI_HALF,
  parameter logic [7:0]  radio_rd_cmd      = `BPC_RADIO_RD_CMD
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic uart_rxd,
  output logic      uart_txd,
  input  wire logic radio_data_ready,
  input  wire logic radio_miso,
  output logic      radio_sclk,
  output logic      radio_mosi,
  output logic      chip_select_line_n,
  input  wire logic app_valid,
  output bpc_mem_s  mem,
  output logic      launch_program_cmd,
  output logic      busy
);

  localparam int          BIT_CYC  = `BPC_CLK_HZ / line_rate_setting;
  localparam logic [11:0] BIT_LAST = 12'(BIT_CYC - 1);
  localparam logic [11:0] HALF_BIT = 12'(BIT_CYC / 2);
  localparam int          NBUF     = `BPC_PAYLOAD_BUF;
  localparam logic [7:0]  LIMIT    = 8'(frame_len_limit);

  typedef struct packed {
    bpc_state_e           st;
    logic                 rx_s1;
    logic                 rx_s2;
    logic                 rdy_s1;
    logic                 rdy_s2;
    logic                 r_busy;
    logic [11:0]          r_cnt;
    logic [3:0]           r_bit;
    logic [7:0]           r_sh;
    logic                 r_v;
    logic                 r_err;
    logic                 t_busy;
    logic [11:0]          t_cnt;
    logic [3:0]           t_bit;
    logic [9:0]           t_sh;
    logic                 txd;
    logic                 src;
    logic                 spi_go;
    logic                 spi_rd;
    logic [7:0]           spi_tx;
    logic                 sent;
    logic [7:0]           len;
    logic [7:0]           idx;
    logic [15:0]          crc;
    logic [7:0]           crc_lo;
    logic [NBUF-1:0][7:0] pay;
    logic [7:0]           reply;
    logic [23:0]          ecnt;
    logic [23:0]          eend;
    bpc_mem_s             mem;
    logic                 launch;
  } bpc_core_s;

  bpc_core_s s;
  bpc_core_s next_s;

  logic       spi_busy;
  logic       spi_done;
  logic [7:0] spi_rx;
  logic       ev_v;
  logic [7:0] ev_d;
  logic [7:0] cmd;
  logic [23:0] addr;
  logic [23:0] last;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `BPC_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  function automatic logic in_app(input logic [23:0] a);
    return (a >= app_lo) && (a <= app_hi);
  endfunction : in_app

  function automatic bpc_core_s fail(input bpc_core_s c, input logic [7:0] code);
    bpc_core_s r;
    r       = c;
    r.reply = code;
    r.st    = ST_REPLY;
    return r;
  endfunction : fail

  bpc_spi_master #(
    .HALF (spi_half)
  ) u_spi (
    .clk                (clk),
    .resetn             (resetn),
    .go                 (s.spi_go),
    .tx_byte            (s.spi_tx),
    .miso               (radio_miso),
    .busy               (spi_busy),
    .done               (spi_done),
    .rx_byte            (spi_rx),
    .sclk               (radio_sclk),
    .mosi               (radio_mosi),
    .chip_select_line_n (chip_select_line_n)
  );

  assign ev_v = s.r_v | (spi_done & s.spi_rd);
  assign ev_d = s.r_v ? s.r_sh : spi_rx;
  assign cmd  = s.pay[0];
  assign addr = {s.pay[3], s.pay[2], s.pay[1]};
  assign last = addr + 24'(s.len) - 24'd5;

  always_comb begin
    next_s        = s;
    next_s.rx_s1  = uart_rxd;
    next_s.rx_s2  = s.rx_s1;
    next_s.rdy_s1 = radio_data_ready;
    next_s.rdy_s2 = s.rdy_s1;
    next_s.r_v    = 1'b0;
    next_s.r_err  = 1'b0;
    next_s.spi_go = 1'b0;
    next_s.mem.wr = 1'b0;
    next_s.launch = 1'b0;
    // serial receiver, lsb first
    if (!s.r_busy) begin
      if (!s.rx_s2) begin
        next_s.r_busy = 1'b1;
        next_s.r_cnt  = HALF_BIT;
        next_s.r_bit  = 4'h0;
      end
    end else if (s.r_cnt != 12'h000) begin
      next_s.r_cnt = s.r_cnt - 12'h001;
    end else begin
      next_s.r_cnt = BIT_LAST;
      next_s.r_bit = s.r_bit + 4'h1;
      if (s.r_bit == 4'h0) begin
        next_s.r_busy = ~s.rx_s2;
      end else if (s.r_bit == 4'h9) begin
        next_s.r_busy = 1'b0;
        next_s.r_v    = s.rx_s2;
        next_s.r_err  = ~s.rx_s2;
      end else begin
        next_s.r_sh = {s.rx_s2, s.r_sh[7:1]};
      end
    end
    // serial transmitter
    if (s.t_busy) begin
      if (s.t_cnt != 12'h000) begin
        next_s.t_cnt = s.t_cnt - 12'h001;
      end else begin
        next_s.t_cnt = BIT_LAST;
        next_s.txd   = s.t_sh[0];
        next_s.t_sh  = {1'b1, s.t_sh[9:1]};
        next_s.t_bit = s.t_bit + 4'h1;
        if (s.t_bit == 4'hA) begin
          next_s.t_busy = 1'b0;
          next_s.txd    = 1'b1;
        end
      end
    end
    if (spi_done) begin
      next_s.spi_rd = 1'b0;
    end
    // radio bytes are fetched while a packet is being gathered
    if (s.st inside {ST_HEAD, ST_LEN, ST_PAY, ST_CRCL, ST_CRCH}) begin
      if (s.rdy_s2 && !spi_busy && !s.spi_go && !s.spi_rd) begin
        next_s.spi_go = 1'b1;
        next_s.spi_rd = 1'b1;
        next_s.spi_tx = radio_rd_cmd;
      end
    end
    case (s.st)
      ST_HEAD: begin
        if (ev_v) begin
          next_s.src = ~s.r_v;
          next_s.crc = `BPC_CRC_INIT;
          next_s.idx = 8'h00;
          if (ev_d == `BPC_START_BYTE) begin
            next_s.st = ST_LEN;
          end else begin
            next_s = fail(next_s, `BPC_RSP_HEADER);
          end
        end
      end
      ST_LEN: begin
        if (s.r_err) begin
          next_s = fail(next_s, `BPC_RSP_FAULT);
        end else if (ev_v) begin
          next_s.len = ev_d;
          if (ev_d == 8'h00) begin
            next_s = fail(next_s, `BPC_RSP_EMPTY);
          end else if (ev_d > LIMIT) begin
            next_s = fail(next_s, `BPC_RSP_OVERSIZE);
          end else begin
            next_s.st = ST_PAY;
          end
        end
      end
      ST_PAY: begin
        if (s.r_err) begin
          next_s = fail(next_s, `BPC_RSP_FAULT);
        end else if (ev_v) begin
          next_s.pay[s.idx[4:0]] = ev_d;
          next_s.crc             = crc_step(s.crc, ev_d);
          next_s.idx             = s.idx + 8'h01;
          if (s.idx == s.len - 8'h01) begin
            next_s.st = ST_CRCL;
          end
        end
      end
      ST_CRCL: begin
        if (s.r_err) begin
          next_s = fail(next_s, `BPC_RSP_FAULT);
        end else if (ev_v) begin
          next_s.crc_lo = ev_d;
          next_s.st     = ST_CRCH;
        end
      end
      ST_CRCH: begin
        if (s.r_err) begin
          next_s = fail(next_s, `BPC_RSP_FAULT);
        end else if (ev_v) begin
          if ({ev_d, s.crc_lo} == s.crc) begin
            next_s.st = ST_EXEC;
          end else begin
            next_s = fail(next_s, `BPC_RSP_CHECKSUM);
          end
        end
      end
      ST_EXEC: begin
        next_s.reply = `BPC_RSP_OK;
        next_s.st    = ST_REPLY;
        case (cmd)
          `BPC_CMD_ERASE_SEG: begin
            if (s.len != 8'h04 || !in_app(addr)) begin
              next_s.reply = `BPC_RSP_BAD_ARG;
            end else begin
              next_s.ecnt = {addr[23:`BPC_SEG_BITS], {`BPC_SEG_BITS{1'b0}}};
              next_s.eend = {addr[23:`BPC_SEG_BITS], {`BPC_SEG_BITS{1'b1}}};
              next_s.st   = ST_ERASE;
            end
          end
          `BPC_CMD_ERASE_ALL: begin
            if (s.len != 8'h01) begin
              next_s.reply = `BPC_RSP_BAD_ARG;
            end else begin
              next_s.ecnt = app_lo;
              next_s.eend = app_hi;
              next_s.st   = ST_ERASE;
            end
          end
          `BPC_CMD_PROGRAM: begin
            if (s.len < 8'h05 || !in_app(addr) || !in_app(last)) begin
              next_s.reply = `BPC_RSP_BAD_ARG;
            end else begin
              next_s.ecnt = addr;
              next_s.idx  = 8'h04;
              next_s.st   = ST_PROG;
            end
          end
          `BPC_CMD_VERSION: begin
            if (s.len != 8'h01) begin
              next_s.reply = `BPC_RSP_BAD_ARG;
            end else begin
              next_s.reply = loader_version;
            end
          end
          `BPC_CMD_LAUNCH: begin
            if (s.len != 8'h01) begin
              next_s.reply = `BPC_RSP_BAD_ARG;
            end else if (!app_valid) begin
              next_s.reply = `BPC_RSP_FAULT;
            end else begin
              next_s.launch = 1'b1;
            end
          end
          default: begin
            next_s.reply = `BPC_RSP_BAD_CMD;
          end
        endcase
      end
      ST_ERASE: begin
        next_s.mem.wr   = 1'b1;
        next_s.mem.addr = s.ecnt;
        next_s.mem.data = `BPC_ERASED_BYTE;
        next_s.ecnt     = s.ecnt + 24'h00_0001;
        if (s.ecnt == s.eend) begin
          next_s.st = ST_REPLY;
        end
      end
      ST_PROG: begin
        next_s.mem.wr   = 1'b1;
        next_s.mem.addr = s.ecnt;
        next_s.mem.data = s.pay[s.idx[4:0]];
        next_s.ecnt     = s.ecnt + 24'h00_0001;
        next_s.idx      = s.idx + 8'h01;
        if (s.idx == s.len - 8'h01) begin
          next_s.st = ST_REPLY;
        end
      end
      ST_REPLY: begin
        // one byte back on the link the packet came in on
        if (!s.sent) begin
          if (!s.src && !s.t_busy) begin
            next_s.t_busy = 1'b1;
            next_s.t_cnt  = BIT_LAST;
            next_s.t_bit  = 4'h0;
            next_s.t_sh   = {1'b1, s.reply, 1'b0};
            next_s.sent   = 1'b1;
          end else if (s.src && !spi_busy && !s.spi_rd && !s.spi_go) begin
            next_s.spi_go = 1'b1;
            next_s.spi_tx = s.reply;
            next_s.sent   = 1'b1;
          end
        end else if (!s.t_busy && !spi_busy && !s.spi_go) begin
          next_s.sent = 1'b0;
          next_s.st   = ST_HEAD;
        end
      end
      default: begin
        next_s.st = ST_HEAD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s        <= '0;
      s.st     <= ST_HEAD;
      s.rx_s1  <= 1'b1;
      s.rx_s2  <= 1'b1;
      s.txd    <= 1'b1;
      s.crc    <= `BPC_CRC_INIT;
      s.t_sh   <= 10'h3FF;
    end else begin
      s <= next_s;
    end
  end

  assign uart_txd           = s.txd;
  assign mem                = s.mem;
  assign launch_program_cmd = s.launch;
  assign busy               = ~s.st[0];

endmodule : bpc_interpreter

// ===== verification/bpc_interpreter_properties.sv
// assertion checker for the boot packet command interpreter
`timescale 1ns/1ps
module bpc_interpreter_properties import bpc_pkg::*; #(
  parameter logic [23:0] app_lo = 24'h00_4400,
  parameter logic [23:0] app_hi = 24'h00_FBFF
) (
  input wire logic     clk,
  input wire logic     resetn,
  input wire logic     uart_rxd,
  input wire logic     uart_txd,
  input wire logic     radio_data_ready,
  input wire logic     radio_miso,
  input wire logic     radio_sclk,
  input wire logic     radio_mosi,
  input wire logic     chip_select_line_n,
  input wire logic     app_valid,
  input wire bpc_mem_s mem,
  input wire logic     launch_program_cmd,
  input wire logic     busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_reset_idle;
    $rose(resetn) |-> uart_txd && chip_select_line_n && !radio_sclk && !radio_mosi
      && !mem.wr && !launch_program_cmd && !busy;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  property p_launch_pulse;
    launch_program_cmd |=> !launch_program_cmd;
  endproperty
  a_launch_pulse: assert property (p_launch_pulse) else $error("launch longer than one cycle");
  property p_launch_valid;
    launch_program_cmd |-> app_valid && !mem.wr;
  endproperty
  a_launch_valid: assert property (p_launch_valid) else $error("launch without valid image");
  property p_wr_busy;
    mem.wr |-> busy;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("memory write while hunting");
  property p_wr_range;
    mem.wr |-> mem.addr >= app_lo && mem.addr <= app_hi;
  endproperty
  a_wr_range: assert property (p_wr_range) else $error("write outside application region");
  property p_wr_seq;
    mem.wr ##1 mem.wr |-> mem.addr == $past(mem.addr) + 24'h00_0001;
  endproperty
  a_wr_seq: assert property (p_wr_seq) else $error("write addresses not consecutive");
  property p_idle_txd;
    !busy |-> uart_txd;
  endproperty
  a_idle_txd: assert property (p_idle_txd) else $error("serial out active while hunting");
  property p_sclk_idle;
    chip_select_line_n |-> !radio_sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("radio clock not idle low");
  property p_start_bit;
    $fell(uart_txd) |-> (!uart_txd)[*8];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit too short");
endmodule : bpc_interpreter_properties

bind bpc_interpreter bpc_interpreter_properties #(.app_lo(app_lo), .app_hi(app_hi)) u_props (
  .clk(clk), .resetn(resetn), .uart_rxd(uart_rxd), .uart_txd(uart_txd),
  .radio_data_ready(radio_data_ready), .radio_miso(radio_miso), .radio_sclk(radio_sclk),
  .radio_mosi(radio_mosi), .chip_select_line_n(chip_select_line_n), .app_valid(app_valid),
  .mem(mem), .launch_program_cmd(launch_program_cmd), .busy(busy)
);

// ===== verification/bpc_host_model.sv
// host model: sends framed packets, collects reply bytes
`timescale 1ns/1ps
module bpc_host_model #(
  parameter int BIT = 20
) (
  input  wire logic clk,
  output logic      uart_rxd,
  input  wire logic uart_txd,
  input  wire logic radio_sclk,
  input  wire logic radio_mosi,
  input  wire logic cs_n,
  output logic      radio_miso,
  output logic      radio_data_ready
);
  logic [7:0] rxq[$];
  logic [7:0] rxb;
  int         n_bad_stop = 0;
  logic [7:0] rdq[$];
  logic [7:0] rrq[$];
  logic [7:0] rsh;
  logic [7:0] rin;
  logic       rsend;

  initial begin
    uart_rxd         = 1'b1;
    radio_miso       = 1'b0;
    radio_data_ready = 1'b0;
  end

  function automatic logic [15:0] crc16(input logic [7:0] p[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (p[i]) begin
      c = c ^ {p[i], 8'h00};
      for (int b = 0; b < 8; b++) begin
        c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
      end
    end
    return c;
  endfunction : crc16

  // one byte, lsb first, BIT cycles per bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      uart_rxd = f[i];
      repeat (BIT - 1) @(negedge clk);
    end
  endtask : send_byte

  task automatic send_raw(input logic [7:0] p[$]);
    foreach (p[i]) send_byte(p[i]);
  endtask : send_raw

  task automatic send_pkt(input logic [7:0] p[$]);
    logic [15:0] c;
    c = crc16(p);
    send_raw({8'h80, 8'(p.size()), p, c[7:0], c[15:8]});
  endtask : send_pkt

  // radio side: hold one framed packet, raise data ready
  task automatic radio_load(input logic [7:0] p[$]);
    logic [15:0] c;
    c = crc16(p);
    rdq = {8'h80, 8'(p.size()), p, c[7:0], c[15:8]};
    @(negedge clk);
    radio_data_ready = 1'b1;
  endtask : radio_load

  // radio bus slave: miso changes on falling sclk, mosi taken on rising
  always begin
    @(negedge cs_n);
    rsend = rdq.size() > 0;
    rsh = rsend ? rdq.pop_front() : 8'h00;
    if (rdq.size() == 0) radio_data_ready <= 1'b0;
    radio_miso <= rsh[7];
    for (int i = 7; i >= 0; i--) begin
      @(posedge radio_sclk);
      rin[i] = radio_mosi;
      @(negedge radio_sclk);
      if (i > 0) radio_miso <= rsh[i - 1];
    end
    @(posedge cs_n);
    if (!rsend) rrq.push_back(rin);
  end

  // reply receiver
  always begin
    @(negedge uart_txd);
    repeat (BIT / 2) @(posedge clk);
    if (uart_txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk);
        rxb[i] = uart_txd;
      end
      repeat (BIT) @(posedge clk);
      if (uart_txd !== 1'b1) n_bad_stop++;
      rxq.push_back(rxb);
    end
  end
endmodule : bpc_host_model

// ===== verification/tb_top.sv
// self-checking bench for the boot packet command interpreter
`timescale 1ns/1ps
module tb_top import bpc_pkg::*;;
  localparam int BIT = 20;
  logic       clk;
  logic       resetn;
  logic       uart_rxd;
  logic       uart_txd;
  logic       radio_sclk;
  logic       radio_mosi;
  logic       cs_n;
  logic       radio_miso;
  logic       radio_rdy;
  logic       app_valid;
  logic       launch;
  logic       busy;
  bpc_mem_s   mem;
  logic [7:0] r;
  logic [23:0] first_a;
  logic [23:0] last_a;
  logic [7:0] wq[$];
  int         num_errors = 0;
  int         n_compared = 0;
  int         n_wr = 0;
  int         n_nff = 0;
  int         n_launch = 0;

  bpc_interpreter #(.line_rate_setting(10_000_000), .spi_half(2)) dut (
    .clk(clk), .resetn(resetn), .uart_rxd(uart_rxd), .uart_txd(uart_txd),
    .radio_data_ready(radio_rdy), .radio_miso(radio_miso), .radio_sclk(radio_sclk),
    .radio_mosi(radio_mosi), .chip_select_line_n(cs_n), .app_valid(app_valid),
    .mem(mem), .launch_program_cmd(launch), .busy(busy)
  );
  bpc_host_model #(.BIT(BIT)) host (
    .clk(clk), .uart_rxd(uart_rxd), .uart_txd(uart_txd), .radio_sclk(radio_sclk),
    .radio_mosi(radio_mosi), .cs_n(cs_n), .radio_miso(radio_miso), .radio_data_ready(radio_rdy)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (mem.wr === 1'b1) begin
      if (n_wr == 0) first_a = mem.addr;
      last_a = mem.addr;
      n_wr++;
      if (mem.data !== 8'hFF) n_nff++;
      wq.push_back(mem.data);
    end
    if (launch === 1'b1) n_launch++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic clr;
    n_wr = 0;
    n_nff = 0;
    n_launch = 0;
    wq.delete();
  endtask : clr

  // host waits for the single reply byte
  task automatic get_reply;
    int n;
    n = 0;
    while (host.rxq.size() == 0 && n < 60000) begin
      @(posedge clk);
      n++;
    end
    repeat (12 * BIT) @(posedge clk);
    check(host.rxq.size(), 1);
    r = (host.rxq.size() > 0) ? host.rxq.pop_front() : 8'hxx;
  endtask : get_reply

  task automatic t_version;
    clr();
    host.send_pkt({8'h19});
    get_reply();
    check(r, 8'h3C);
    check(n_wr, 0);
  endtask : t_version

  task automatic t_errors;
    clr();
    host.send_byte(8'h55);
    get_reply();
    check(r, 8'h51);
    host.send_raw({8'h80, 8'h00});
    get_reply();
    check(r, 8'h53);
    host.send_raw({8'h80, 8'd20});
    get_reply();
    check(r, 8'h54);
    host.send_raw({8'h80, 8'h01, 8'h19, 8'h00, 8'h00});
    get_reply();
    check(r, 8'h52);
    host.send_pkt({8'h20});
    get_reply();
    check(r, 8'h56);
    host.send_pkt({8'h19, 8'h00});
    get_reply();
    check(r, 8'hC5);
    host.send_pkt({8'h10, 8'h00, 8'h00, 8'h00, 8'hAA});
    get_reply();
    check(r, 8'hC5);
    check(n_wr, 0);
  endtask : t_errors

  task automatic t_program;
    logic [7:0] p[$];
    clr();
    p = {8'h10, 8'h12, 8'h45, 8'h00};
    for (int i = 0; i < 15; i++) p.push_back(8'(i * 7 + 1));
    host.send_pkt(p);
    get_reply();
    check(r, 8'h00);
    check(n_wr, 15);
    check(first_a, 24'h00_4512);
    check(last_a, 24'h00_4520);
    foreach (wq[i]) check(wq[i], 8'(i * 7 + 1));
  endtask : t_program

  task automatic t_erase;
    clr();
    host.send_pkt({8'h12, 8'h34, 8'h46, 8'h00});
    get_reply();
    check(r, 8'h00);
    check(n_wr, 512);
    check(first_a, 24'h00_4600);
    check(last_a, 24'h00_47FF);
    check(n_nff, 0);
    clr();
    host.send_pkt({8'h15});
    get_reply();
    check(r, 8'h00);
    check(n_wr, 47104);
    check(first_a, 24'h00_4400);
    check(last_a, 24'h00_FBFF);
    check(n_nff, 0);
  endtask : t_erase

  task automatic t_launch;
    @(negedge clk) app_valid = 1'b1;
    clr();
    host.send_pkt({8'h1C});
    get_reply();
    check(r, 8'h00);
    check(n_launch, 1);
    @(negedge clk) app_valid = 1'b0;
    clr();
    host.send_pkt({8'h1C});
    get_reply();
    check(r, 8'h55);
    check(n_launch, 0);
  endtask : t_launch

  task automatic t_radio;
    int n;
    n = 0;
    host.radio_load({8'h19});
    while (host.rrq.size() == 0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    check(host.rrq.size(), 1);
    check((host.rrq.size() > 0) ? host.rrq.pop_front() : 8'hxx, 8'h3C);
    repeat (40) @(posedge clk);
    check(host.rdq.size(), 0);
  endtask : t_radio

  task automatic give_verdict;
    $display("errors %0d, compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    resetn = 1'b0;
    app_valid = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    t_version();
    t_errors();
    t_version();
    t_program();
    t_erase();
    t_launch();
    t_radio();
    check(host.n_bad_stop, 0);
    give_verdict();
  end

  initial begin
    repeat (99000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule : tb_top
